/* File: verilog/srs_pkg.sv */
// Purpose: Shared constants and types for the serial register access sequencer
// Assumes: 16-bit command frames, 64 nine-bit registers, eight channel pairs
// Notes: Stack rows live in the upper half of the register file
package srs_pkg;
  // Command word layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_WR_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 9;
  localparam int DATA_MSB = 8;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;

  // Register file
  localparam int REG_COUNT = 64;
  localparam logic [5:0] CFG_ADDR = 6'h02;
  localparam int CFG_SEQUENCER_ENABLE_PIN_BIT = 0;
  localparam int CFG_BURST_BIT = 1;
  localparam logic [5:0] STACK_BASE = 6'h20;
  localparam int STEP_LAST_BIT = 7;
  localparam int STEP_B_MSB = 6;
  localparam int STEP_B_LSB = 3;
  localparam int STEP_A_MSB = 2;
  localparam logic [4:0] STEP_MAX = 5'h1f;
  localparam logic [8:0] REG_RESET = 9'h000;

  // Synchronised pin vector positions
  localparam int PIN_COUNT = 9;
  localparam int P_RX = 8;
  localparam int P_IFSEL = 7;
  localparam int P_CONVERSION_START_PIN = 6;
  localparam int P_SEQUENCER_ENABLE_PIN = 5;
  localparam int P_BURST = 4;
  localparam int P_SWMODE = 3;
  localparam int P_RANGE_MSB = 2;

  // Cycles after reset release before straps are taken
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
  localparam int RESULT_SLOTS = 8;
  localparam logic [3:0] RES_NONE = 4'h0;

  // Gray-coded along INIT -> IDLE -> CONV
  typedef enum logic [1:0]
  {
    SRS_INIT = 2'b00,
    SRS_IDLE = 2'b01,
    SRS_CONV = 2'b11
  } srs_state_t;
endpackage

/* File: verilog/srs_link_if.sv */
// Purpose: Carrier between the serial shifter and the sequencer core
// Assumes: rx_word is stable whenever rx_toggle has settled
// Notes: tx words are held by the core between frames
`timescale 1ns/1ps
interface srs_link_if;
  logic [15:0] rx_word;
  logic rx_toggle;
  logic [15:0] tx_a;
  logic [15:0] tx_b;

  modport link
  (
    output rx_word,
    output rx_toggle,
    input tx_a,
    input tx_b
  );

  modport core
  (
    input rx_word,
    input rx_toggle,
    output tx_a,
    output tx_b
  );
endinterface

/* File: verilog/srs_serial_link.sv */
// Purpose: Serial clock domain shifter for command in and data out
// Assumes: Host sends whole 16-bit frames, changes sdi on falling sclk
// Notes: Bit counter wraps every 16 edges; an aborted frame misaligns it
`timescale 1ns/1ps
module srs_serial_link
(
  input wire logic sclk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sdi,
  srs_link_if.link lnk,
  output logic sdo_a,
  output logic sdo_b
);

  typedef struct packed
  {
    logic [3:0] cnt;
    logic [15:0] shin;
    logic [15:0] sha;
    logic [15:0] shb;
    logic [15:0] rxw;
    logic tog;
    logic oa;
    logic ob;
  } srs_link_state_t;

  srs_link_state_t link_reg;
  srs_link_state_t link_next;

  // Shift on rising sclk only inside a frame
  always_comb
  begin
    link_next = link_reg;
    if (!cs_n)
    begin
      link_next.cnt = link_reg.cnt + 4'h1;
      link_next.shin = {link_reg.shin[14:0], sdi};
      if (link_reg.cnt == 4'h0)
      begin
        // MSB goes out on the first rising edge
        link_next.oa = lnk.tx_a[15];
        link_next.ob = lnk.tx_b[15];
        link_next.sha = {lnk.tx_a[14:0], 1'b0};
        link_next.shb = {lnk.tx_b[14:0], 1'b0};
      end
      else
      begin
        link_next.oa = link_reg.sha[15];
        link_next.ob = link_reg.shb[15];
        link_next.sha = {link_reg.sha[14:0], 1'b0};
        link_next.shb = {link_reg.shb[14:0], 1'b0};
      end
      if (link_reg.cnt == srs_pkg::FRAME_LAST_BIT)
      begin
        // Toggle crosses to mclk; word stays put for a whole frame
        link_next.rxw = {link_reg.shin[14:0], sdi};
        link_next.tog = ~link_reg.tog;
      end
    end
  end

  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
      link_reg <= '0;
    else
      link_reg <= link_next;
  end

  assign lnk.rx_word = link_reg.rxw;
  assign lnk.rx_toggle = link_reg.tog;
  assign sdo_a = link_reg.oa;
  assign sdo_b = link_reg.ob;
endmodule

/* File: verilog/srs_sequencer.sv */
// Purpose: Serial register access and conversion sequencer core
// Assumes: Converter core signals conv_done one cycle per pair
// Notes: Host leaves a few mclk cycles idle between frames
`timescale 1ns/1ps
// How it works
// - One 16-bit frame per command, MSB first
// - Top bit one marks a write
// - Bits fourteen to nine hold register address
// - Write stores low nine bits
// - Top bit zero marks a read
// - Read ignores the low nine bits
// - Hardware sequence starts at pair zero, ascends
// - Software stack of 32 programmable steps
// - Burst converts the whole sequence per start
// - No burst converts one step per start
// - Sequencer enable strap latched at reset release
// - Initial end pair from straps at release
// - New range applies from the next sequence
// - Select pins form n, pairs zero..n
// - Start edge raises busy, done lowers it
// - Chip select drives outputs, rising edges shift
// - Serial port works only when selected high
module srs_sequencer
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo_a,
  output logic sdo_a_oe_n,
  output logic sdo_b,
  output logic sdo_b_oe_n,
  input wire logic interface_select_pin,
  input wire logic conversion_start_pin,
  input wire logic sequencer_enable_pin,
  input wire logic burst_pin,
  input wire logic sw_mode_pin,
  input wire logic [2:0] channel_range_select_pins,
  output logic busy,
  output logic conv_go,
  output logic [2:0] conv_sel_a,
  output logic [3:0] conv_sel_b,
  input wire logic conv_done,
  input wire logic [15:0] conv_result_a,
  input wire logic [15:0] conv_result_b
);

  typedef struct packed
  {
    srs_pkg::srs_state_t st;
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] f;
    logic [1:0] settle;
    logic hw_sequencer_enable_pin;
    logic hw_burst;
    logic sw_mode;
    logic [2:0] range;
    logic [4:0] step;
    logic busy;
    logic go;
    logic [2:0] sel_a;
    logic [3:0] sel_b;
    logic [63:0][8:0] regs;
    logic [7:0][15:0] res_a;
    logic [7:0][15:0] res_b;
    logic [3:0] res_n;
    logic [3:0] rd_ptr;
    logic [15:0] tx_a;
    logic [15:0] tx_b;
  } srs_core_state_t;

  srs_core_state_t core_reg;
  srs_core_state_t core_next;
  srs_link_if lnk();

  logic rx_evt;
  logic conv_rise;
  logic sequencer_enable_pin_eff;
  logic burst_eff;
  logic last_step;
  logic wr_hit;
  logic rd_hit;
  logic [5:0] cmd_addr;
  logic [8:0] step_entry;

  // Select pair for a step: bank B bit 3 picks a diagnostic channel
  function automatic logic [6:0] step_sel(input logic sw, input logic [4:0] step, input logic [8:0] entry);
    if (sw)
      step_sel = entry[srs_pkg::STEP_B_MSB:0];
    else
      step_sel = {1'b0, step[2:0], step[2:0]};
  endfunction

  // Stack row address for a step
  function automatic logic [5:0] stack_addr(input logic [4:0] step);
    stack_addr = srs_pkg::STACK_BASE | {1'b0, step};
  endfunction

  srs_serial_link u_link
  (
    .sclk(sclk),
    .sys_rst(sys_rst),
    .cs_n(cs_n),
    .sdi(sdi),
    .lnk(lnk.link),
    .sdo_a(sdo_a),
    .sdo_b(sdo_b)
  );

  // Decode of the frame word and the effective mode
  always_comb
  begin
    cmd_addr = lnk.rx_word[srs_pkg::ADDR_MSB:srs_pkg::ADDR_LSB];
    step_entry = core_reg.regs[stack_addr(core_reg.step)];
    rx_evt = (core_reg.s2[srs_pkg::P_RX] == core_reg.s3[srs_pkg::P_RX])
      && (core_reg.s3[srs_pkg::P_RX] != core_reg.f[srs_pkg::P_RX])
      && core_reg.f[srs_pkg::P_IFSEL] && (core_reg.st != srs_pkg::SRS_INIT);
    conv_rise = (core_reg.s2[srs_pkg::P_CONVERSION_START_PIN] == core_reg.s3[srs_pkg::P_CONVERSION_START_PIN])
      && core_reg.s3[srs_pkg::P_CONVERSION_START_PIN] && !core_reg.f[srs_pkg::P_CONVERSION_START_PIN];
    wr_hit = rx_evt && lnk.rx_word[srs_pkg::CMD_WR_BIT];
    rd_hit = rx_evt && !lnk.rx_word[srs_pkg::CMD_WR_BIT];
    sequencer_enable_pin_eff = core_reg.sw_mode ? core_reg.regs[srs_pkg::CFG_ADDR][srs_pkg::CFG_SEQUENCER_ENABLE_PIN_BIT] : core_reg.hw_sequencer_enable_pin;
    burst_eff = sequencer_enable_pin_eff && (core_reg.sw_mode ?
      core_reg.regs[srs_pkg::CFG_ADDR][srs_pkg::CFG_BURST_BIT] : core_reg.hw_burst);
    if (!sequencer_enable_pin_eff)
      last_step = 1'b1;
    else if (core_reg.sw_mode)
      last_step = step_entry[srs_pkg::STEP_LAST_BIT] || (core_reg.step == srs_pkg::STEP_MAX);
    else
      last_step = (core_reg.step[2:0] == core_reg.range);
  end

  // Next state of the whole core
  always_comb
  begin
    core_next = core_reg;
    core_next.go = 1'b0;
    // Three-stage sync; a change counts once stages two and three agree
    core_next.s1 = {lnk.rx_toggle, interface_select_pin, conversion_start_pin, sequencer_enable_pin,
      burst_pin, sw_mode_pin, channel_range_select_pins};
    core_next.s2 = core_reg.s1;
    core_next.s3 = core_reg.s2;
    for (int i = 0; i < srs_pkg::PIN_COUNT; i++)
    begin
      if (core_reg.s2[i] == core_reg.s3[i])
        core_next.f[i] = core_reg.s3[i];
    end

    // Frame handling: write stores, read prepares the next frame's data
    if (wr_hit)
      core_next.regs[cmd_addr] = lnk.rx_word[srs_pkg::DATA_MSB:0];
    if (rx_evt)
    begin
      if (core_reg.rd_ptr < core_reg.res_n)
      begin
        core_next.tx_a = core_reg.res_a[core_reg.rd_ptr[2:0]];
        core_next.tx_b = core_reg.res_b[core_reg.rd_ptr[2:0]];
        core_next.rd_ptr = core_reg.rd_ptr + 4'h1;
      end
      else if (rd_hit)
      begin
        // Data bits of the read word play no part here
        core_next.tx_a = {7'h00, core_reg.regs[cmd_addr]};
        core_next.tx_b = 16'h0000;
      end
      else
      begin
        core_next.tx_a = 16'h0000;
        core_next.tx_b = 16'h0000;
      end
    end

    case (core_reg.st)
      srs_pkg::SRS_INIT:
      begin
        // Wait for the pin sync to fill before taking straps
        core_next.settle = core_reg.settle + 2'h1;
        if (core_reg.settle == srs_pkg::STRAP_SETTLE_CYCLES)
        begin
          // Filter only settles on this edge; the registered copy is still clear
          core_next.hw_sequencer_enable_pin = core_next.f[srs_pkg::P_SEQUENCER_ENABLE_PIN];
          core_next.hw_burst = core_next.f[srs_pkg::P_BURST];
          core_next.sw_mode = core_next.f[srs_pkg::P_SWMODE];
          core_next.range = core_next.f[srs_pkg::P_RANGE_MSB:0];
          core_next.st = srs_pkg::SRS_IDLE;
        end
      end
      srs_pkg::SRS_IDLE:
      begin
        if (conv_rise)
        begin
          core_next.busy = 1'b1;
          core_next.go = 1'b1;
          {core_next.sel_b, core_next.sel_a} = step_sel(core_reg.sw_mode, core_reg.step, step_entry);
          core_next.res_n = srs_pkg::RES_NONE;
          core_next.rd_ptr = srs_pkg::RES_NONE;
          core_next.st = srs_pkg::SRS_CONV;
        end
      end
      srs_pkg::SRS_CONV:
      begin
        if (conv_done)
        begin
          // More than eight burst pairs all overwrite slot zero
          core_next.res_a[core_reg.res_n[2:0]] = conv_result_a;
          core_next.res_b[core_reg.res_n[2:0]] = conv_result_b;
          if (core_reg.res_n != 4'(srs_pkg::RESULT_SLOTS))
            core_next.res_n = core_reg.res_n + 4'h1;
          if (last_step)
          begin
            core_next.step = 5'h00;
            core_next.range = core_reg.f[srs_pkg::P_RANGE_MSB:0];
          end
          else
          begin
            core_next.step = core_reg.step + 5'h01;
          end
          if (burst_eff && !last_step)
          begin
            // Next pair starts without another start edge
            core_next.go = 1'b1;
            {core_next.sel_b, core_next.sel_a} = step_sel(core_reg.sw_mode, core_next.step,
              core_reg.regs[stack_addr(core_next.step)]);
          end
          else
          begin
            core_next.busy = 1'b0;
            core_next.st = srs_pkg::SRS_IDLE;
            core_next.tx_a = core_next.res_a[0];
            core_next.tx_b = core_next.res_b[0];
            core_next.rd_ptr = 4'h1;
          end
        end
      end
      default:
      begin
        core_next.st = srs_pkg::SRS_INIT;
      end
    endcase
  end

  // Straps are taken by the INIT state, never from the reset itself
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_reg <= '0;
      core_reg.st <= srs_pkg::SRS_INIT;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  // Outputs float unless the frame is open and serial is selected
  assign sdo_a_oe_n = cs_n | ~core_reg.f[srs_pkg::P_IFSEL];
  assign sdo_b_oe_n = cs_n | ~core_reg.f[srs_pkg::P_IFSEL];
  assign lnk.tx_a = core_reg.tx_a;
  assign lnk.tx_b = core_reg.tx_b;
  assign busy = core_reg.busy;
  assign conv_go = core_reg.go;
  assign conv_sel_a = core_reg.sel_a;
  assign conv_sel_b = core_reg.sel_b;

  // Checks on the core's own behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  busy_rises_a: assert property ((core_reg.st == srs_pkg::SRS_IDLE) && conv_rise |=> busy && conv_go)
    else $error("busy did not rise after start edge");
  busy_falls_a: assert property ($fell(busy) |-> $past(conv_done) && (core_reg.st == srs_pkg::SRS_IDLE))
    else $error("busy fell without conversion done");
  write_store_a: assert property (wr_hit |=> core_reg.regs[$past(cmd_addr)] == $past(lnk.rx_word[8:0]))
    else $error("write data not stored");
  read_keeps_a: assert property (rd_hit |=> core_reg.regs == $past(core_reg.regs))
    else $error("read command changed a register");
  read_data_a: assert property (rd_hit && (core_reg.rd_ptr >= core_reg.res_n) && !conv_done
    |=> core_reg.tx_a == {7'h00, $past(core_reg.regs[cmd_addr])})
    else $error("read data not prepared for next frame");
  first_pair_a: assert property ((core_reg.st == srs_pkg::SRS_IDLE) && conv_rise && !core_reg.sw_mode
    && (core_reg.step == 5'h00) |=> (conv_sel_a == 3'h0) && (conv_sel_b == 4'h0))
    else $error("hardware sequence did not start at pair zero");
  wrap_zero_a: assert property ((core_reg.st == srs_pkg::SRS_CONV) && conv_done && last_step
    |=> core_reg.step == 5'h00)
    else $error("sequencer did not wrap to pair zero");
  range_bound_a: assert property (busy && !core_reg.sw_mode |-> conv_sel_a <= core_reg.range)
    else $error("pair beyond configured end");
  burst_next_a: assert property ((core_reg.st == srs_pkg::SRS_CONV) && conv_done && burst_eff && !last_step
    |=> conv_go ##1 !conv_go)
    else $error("burst did not launch next pair");
  single_step_a: assert property ((core_reg.st == srs_pkg::SRS_CONV) && conv_done && !burst_eff
    |=> !busy && (core_reg.st == srs_pkg::SRS_IDLE))
    else $error("non-burst start converted more than one step");
  strap_hold_a: assert property ((core_reg.st != srs_pkg::SRS_INIT) |=> $stable(core_reg.hw_sequencer_enable_pin)
    && $stable(core_reg.hw_burst))
    else $error("strap setting changed after reset release");
  port_off_a: assert property (!core_reg.f[srs_pkg::P_IFSEL] |-> sdo_a_oe_n && sdo_b_oe_n && !rx_evt)
    else $error("serial port active while deselected");

  burst_run_c: cover property (burst_eff && conv_go ##[1:200] $fell(busy));
  reg_read_c: cover property (rd_hit ##[1:1000] rx_evt);
  reg_write_c: cover property (wr_hit);
  wrap_c: cover property (conv_done && last_step && core_reg.step != 5'h00);
endmodule

/* File: verif/srs_host_model.sv */
// Purpose: Host controller model driving the serial command port
// Assumes: sclk idles low, device shifts out on rising sclk
// Notes: Data line is inverted when deselected so stale bits never look valid
`timescale 1ns/1ps
module srs_host_model
(
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_a,
  input wire logic sdo_b,
  input wire logic sdo_a_oe_n
);
  logic [15:0] rx_a;
  logic [15:0] rx_b;
  logic oe_seen;
  logic chk;
  event frame_done;

  // Idle: clock still, deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    chk = 1'b0;
  end

  // One whole frame; sdi moves on falling sclk, sdo taken before next rise
  task automatic xfer(input logic [15:0] cmd, input logic check);
    int i;
    begin
      #7;
      cs_n = 1'b0;
      for (i = 15; i >= 0; i--)
      begin
        sdi = cmd[i];
        #62.5 sclk = 1'b1;
        #62.5 sclk = 1'b0;
        rx_a = {rx_a[14:0], sdo_a};
        rx_b = {rx_b[14:0], sdo_b};
        if (i == 8)
          oe_seen = sdo_a_oe_n;
      end
      cs_n = 1'b1;
      sdi = ~sdi;
      chk = check;
      -> frame_done;
      // Gap lets the core take the word and load the answer
      #400;
    end
  endtask
endmodule

/* File: verif/spi_register_access_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the serial register access sequencer
// Assumes: Straps set per scenario, converter model answers a few cycles after go
// Notes: Expected frames and pairs are queued by the driver, popped by monitors
`timescale 1ns/1ps
module spi_register_access_sequencer_tb_top;
  logic mclk, sys_rst, sclk, cs_n, sdi, sdo_a, sdo_a_oe_n, sdo_b, sdo_b_oe_n;
  logic interface_select_pin, conversion_start_pin, sequencer_enable_pin, burst_pin, sw_mode_pin;
  logic [2:0] channel_range_select_pins;
  logic busy, conv_go, conv_done;
  logic [2:0] conv_sel_a;
  logic [3:0] conv_sel_b;
  logic [15:0] conv_result_a, conv_result_b;
  logic [2:0] cnt_reg;
  logic [31:0] rv;
  logic [8:0] d;
  logic [31:0] exp_sel;
  logic [31:0] fq[$];
  logic [31:0] rq[$];
  logic [6:0] sq[$];
  int num_errors, total_checks, seed, i;

  srs_sequencer dut_u (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo_a(sdo_a), .sdo_a_oe_n(sdo_a_oe_n), .sdo_b(sdo_b), .sdo_b_oe_n(sdo_b_oe_n),
    .interface_select_pin(interface_select_pin), .conversion_start_pin(conversion_start_pin),
    .sequencer_enable_pin(sequencer_enable_pin), .burst_pin(burst_pin), .sw_mode_pin(sw_mode_pin),
    .channel_range_select_pins(channel_range_select_pins), .busy(busy), .conv_go(conv_go),
    .conv_sel_a(conv_sel_a), .conv_sel_b(conv_sel_b), .conv_done(conv_done),
    .conv_result_a(conv_result_a), .conv_result_b(conv_result_b));

  srs_host_model host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_a(sdo_a), .sdo_b(sdo_b),
    .sdo_a_oe_n(sdo_a_oe_n));

  always #10 mclk = ~mclk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      total_checks++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task automatic wrap_up;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Converter core: done six cycles after go, random results remembered
  always @(posedge mclk)
  begin
    conv_done <= 1'b0;
    if (sys_rst)
      cnt_reg <= 3'h0;
    else if (conv_go === 1'b1)
      cnt_reg <= 3'h6;
    else if (cnt_reg != 3'h0)
    begin
      cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h1)
      begin
        rv = $random(seed);
        conv_done <= 1'b1;
        conv_result_a <= rv[31:16];
        conv_result_b <= rv[15:0];
        rq.push_back(rv);
      end
    end
  end

  // Each go must carry the next noted pair
  // An unnoted go can never match the all-ones marker
  always @(posedge mclk)
    if (conv_go === 1'b1)
    begin
      exp_sel = (sq.size() > 0) ? {25'h0, sq.pop_front()} : 32'hffffffff;
      check("conv_sel", {25'h0, conv_sel_a, conv_sel_b}, exp_sel);
    end

  // Output enable B follows the synced select while a frame is open
  always @(posedge sclk)
    check("sdo_b_oe_n", {31'h0, sdo_b_oe_n}, {31'h0, ~interface_select_pin});

  // Each checked frame compares both serial outputs with the oldest note
  always @(host_u.frame_done)
    if (host_u.chk === 1'b1)
      check("frame", {host_u.rx_a, host_u.rx_b}, fq.pop_front());

  // Full reset with straps held across the release
  task automatic reset_dut(input logic en, input logic bu, input logic [2:0] rng);
    begin
      @(posedge mclk);
      sequencer_enable_pin <= en;
      burst_pin <= bu;
      channel_range_select_pins <= rng;
      sys_rst <= 1'b1;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge mclk);
    end
  endtask

  // Read command with junk low bits, then a follow-up frame fetches the data
  task automatic rd(input logic [5:0] addr, input logic [8:0] exp);
    begin
      rv = $random(seed);
      host_u.xfer({1'b0, addr, rv[8:0]}, 1'b0);
      fq.push_back({7'h00, exp, 16'h0000});
      host_u.xfer(16'h0000, 1'b1);
    end
  endtask

  // One start pulse; pairs lo..hi expected; range pins changed while busy
  task automatic conv(input logic [2:0] lo, input logic [2:0] hi, input logic [2:0] nr);
    int k;
    begin
      // Software mode pairs are noted by the caller from the stack rows
      for (k = lo; k <= hi; k++)
        if (sw_mode_pin !== 1'b1)
          sq.push_back({k[2:0], 1'b0, k[2:0]});
      @(posedge mclk);
      conversion_start_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      conversion_start_pin <= 1'b0;
      channel_range_select_pins <= nr;
      @(negedge mclk);
      check("busy high", {31'h0, busy}, 32'h1);
      k = 0;
      while (busy !== 1'b0 && k < 500)
      begin
        @(negedge mclk);
        k++;
      end
      check("busy low", {31'h0, busy}, 32'h0);
      for (k = lo; k <= hi; k++)
      begin
        fq.push_back(rq.pop_front());
        host_u.xfer(16'h0000, 1'b1);
      end
      check("pairs left", 32'(sq.size() + rq.size()), 32'h0);
    end
  endtask

  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    interface_select_pin = 1'b1;
    conversion_start_pin = 1'b0;
    sequencer_enable_pin = 1'b1;
    burst_pin = 1'b1;
    sw_mode_pin = 1'b0;
    channel_range_select_pins = 3'h2;
    conv_done = 1'b0;
    conv_result_a = 16'h0000;
    conv_result_b = 16'h0000;
    cnt_reg = 3'h0;
    seed = 22108;
    num_errors = 0;
    total_checks = 0;
    reset_dut(1'b1, 1'b1, 3'h2);
    // Writes of random data, read back; untouched row keeps its reset value
    for (i = 0; i < 4; i++)
    begin
      rv = $random(seed);
      d = rv[8:0];
      host_u.xfer({1'b1, 6'h10 + i[5:0], d}, 1'b0);
      rd(6'h10 + i[5:0], d);
    end
    rd(6'h3f, 9'h000);
    // Deselected serial port: write ignored, outputs left floating
    @(posedge mclk);
    interface_select_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    host_u.xfer({1'b1, 6'h13, ~d}, 1'b0);
    check("oe_n deselected", {31'h0, host_u.oe_seen}, 32'h1);
    @(posedge mclk);
    interface_select_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(6'h13, d);
    check("oe_n selected", {31'h0, host_u.oe_seen}, 32'h0);
    // Burst: pairs 0..2, then new range 1 applies to the next sequence
    conv(3'h0, 3'h2, 3'h1);
    conv(3'h0, 3'h1, 3'h1);
    // No burst, range 1: one step per start, wraps back to pair 0
    reset_dut(1'b1, 1'b0, 3'h1);
    conv(3'h0, 3'h0, 3'h1);
    conv(3'h1, 3'h1, 3'h1);
    conv(3'h0, 3'h0, 3'h1);
    // Sequencer strapped off: every start stays on pair 0
    reset_dut(1'b0, 1'b0, 3'h7);
    conv(3'h0, 3'h0, 3'h7);
    conv(3'h0, 3'h0, 3'h7);
    // Software mode: two stack rows, the second marked last, burst on
    @(posedge mclk);
    sw_mode_pin <= 1'b1;
    reset_dut(1'b0, 1'b0, 3'h0);
    host_u.xfer({1'b1, 6'h20, 9'h035}, 1'b0);
    host_u.xfer({1'b1, 6'h21, 9'h0cb}, 1'b0);
    host_u.xfer({1'b1, 6'h02, 9'h003}, 1'b0);
    sq.push_back({3'h5, 4'h6});
    sq.push_back({3'h3, 4'h9});
    conv(3'h0, 3'h1, 3'h0);
    wrap_up();
  end

  // Watchdog well beyond the longest expected run
  initial
  begin
    #500000;
    num_errors++;
    wrap_up();
  end
endmodule
